// ===== rtl/adcc_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_OFS_CTRL 5'h00
`define ADCC_OFS_CLK 5'h04
`define ADCC_OFS_RHI 5'h08
`define ADCC_OFS_RLO 5'h0C
`define ADCC_OFS_STAT 5'h10
`define ADCC_OFS_IEN 5'h14
`define ADCC_CTRL_START 7
`define ADCC_CTRL_PEND 6
`define ADCC_CTRL_SEL_HI 5
`define ADCC_CTRL_SEL_LO 3
`define ADCC_CTRL_CH_HI 2
`define ADCC_CTRL_CH_LO 0
`define ADCC_STAT_DONE 0
`define ADCC_STAT_LATE 1
`define ADCC_IEN_CONV 0
`define ADCC_IEN_LATE 1
`define ADCC_IEN_GROUP 2
`define ADCC_IEN_GLOBAL 3
`define ADCC_SEL_RST 3'h0
`define ADCC_CH_RST 3'h0
`define ADCC_CLK_RST 2'h0
`define ADCC_IEN_RST 4'h0
`define ADCC_INSTR_CLKS 4
`define ADCC_START_WINDOW_INSTR 10
`define ADCC_START_WINDOW_CLKS (`ADCC_START_WINDOW_INSTR * `ADCC_INSTR_CLKS)
`define ADCC_DIV_BASE 4
`define ADCC_MSB 4'hB
`endif

// ===== rtl/adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } adcc_avs_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } adcc_avs_rsp_t;
  typedef struct packed {
    logic power;
    logic [2:0] channel;
    logic reset;
    logic [11:0] trial;
  } adcc_ana_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_CONV} adcc_phase_t;
  typedef struct packed {
    logic comp_meta;
    logic comp_sync;
    logic ack;
    logic [31:0] readdata;
    logic start;
    logic [2:0] sel;
    logic [2:0] ch;
    logic pending;
    logic [1:0] clk_sel;
    logic [11:0] result;
    logic [11:0] sar;
    logic [3:0] bit_idx;
    logic [4:0] div_cnt;
    logic [5:0] win_cnt;
    logic st_done;
    logic st_late;
    logic [3:0] ien;
    adcc_phase_t phase;
  } adcc_state_t;
endpackage : adcc_pkg

// ===== rtl/adcc_top.sv
// Converter control: registers, start sequencing, successive approximation
// Contract
// - Clearing the channel-selection bits needs no re-initialisation pulse.
// - Zero channel-selection bits power the converter down.
// - Pending flag is high while converting, low when done; software polls it.
// - Result is offered as upper and lower bytes, readable in either order.
// - Conversion end sets the request flag; the handler writes it to zero.
// - Interrupt needs converter, group and global enables all set; the late-start request here needs only the global and late enables.
// - Clock select pattern 01 gives system clock divided by eight.
// - Control value 0x20 powers up and connects input zero.
// - Result is 12 bits, full scale codes all ones.
// - Half-step input offset shifts code transitions; last one 1.5 steps below.
// - One instruction cycle is four system clocks.
// - Upper byte holds bits 11..4; lower byte bits 3..0 in its upper nibble.
// - Conversion clock is system clock over a ratio from two select bits.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`include "adcc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module adcc_top #(
  parameter int NUM_CH = 6
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire adcc_pkg::adcc_avs_req_t AVS_REQ,
  output adcc_pkg::adcc_avs_rsp_t AVS_RSP,
  output logic IRQ,
  output adcc_pkg::adcc_ana_t ANA,
  input wire logic COMP_IN
);
  import adcc_pkg::*;

  adcc_state_t s;
  adcc_state_t next_s;
  logic req;
  logic wr;
  logic rd;
  logic fin;
  logic [11:0] fin_code;
  logic launch;

  // Channel field is three bits wide, so more inputs cannot be addressed
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_chk
    $error("NUM_CH must lie between 1 and 8");
  end

  // Last count of the conversion clock divider for a select code
  function automatic logic [4:0] div_last(input logic [1:0] sel);
    div_last = 5'((`ADCC_DIV_BASE << sel) - 1);
  endfunction : div_last

  // Register read decode; unmapped offsets read as zero
  function automatic logic [31:0] read_mux(input logic [4:0] a, input adcc_state_t st);
    read_mux = 32'h0;
    case (a)
      `ADCC_OFS_CTRL: read_mux = {24'h0, st.start, st.pending, st.sel, st.ch};
      `ADCC_OFS_CLK: read_mux = {30'h0, st.clk_sel};
      `ADCC_OFS_RHI: read_mux = {24'h0, st.result[11:4]};
      `ADCC_OFS_RLO: read_mux = {24'h0, st.result[3:0], 4'h0};
      `ADCC_OFS_STAT: read_mux = {30'h0, st.st_late, st.st_done};
      `ADCC_OFS_IEN: read_mux = {28'h0, st.ien};
      default: read_mux = 32'h0;
    endcase
  endfunction : read_mux

  // Next-state logic for bus slave, sequencer and flags
  always_comb begin
    logic [2:0] w_sel;
    logic w_start;
    logic [3:0] nb;
    w_sel = AVS_REQ.writedata[`ADCC_CTRL_SEL_HI:`ADCC_CTRL_SEL_LO];
    w_start = AVS_REQ.writedata[`ADCC_CTRL_START];
    nb = s.bit_idx - 4'h1;
    next_s = s;
    fin = 1'b0;
    fin_code = s.sar;
    launch = 1'b0;
    // Two-stage synchroniser on the comparator pin
    next_s.comp_meta = COMP_IN;
    next_s.comp_sync = s.comp_meta;
    // One wait state per access; readdata is ready in the ack cycle
    req = AVS_REQ.read | AVS_REQ.write;
    next_s.ack = req & ~s.ack;
    wr = AVS_REQ.write & s.ack;
    rd = AVS_REQ.read & s.ack;
    if (req && !s.ack) begin
      next_s.readdata = read_mux(AVS_REQ.address, s);
    end
    if (s.phase == ST_RESET && s.win_cnt != 6'h3F) begin
      next_s.win_cnt = s.win_cnt + 6'h1;
    end
    unique case (s.phase)
      ST_IDLE: begin
      end
      ST_RESET: begin
      end
      ST_CONV: begin
        if (s.div_cnt == div_last(s.clk_sel)) begin
          next_s.div_cnt = 5'h0;
          // trial bit kept when input is at or above it
          if (!s.comp_sync) begin
            fin_code[s.bit_idx] = 1'b0;
          end
          next_s.sar = fin_code;
          if (s.bit_idx == 4'h0) begin
            // result, flag and request move together
            fin = 1'b1;
            next_s.result = fin_code;
            next_s.pending = 1'b0;
            next_s.phase = ST_IDLE;
          end else begin
            next_s.bit_idx = nb;
            next_s.sar[nb] = 1'b1;
          end
        end else begin
          next_s.div_cnt = s.div_cnt + 5'h1;
        end
      end
    endcase
    // Register writes take effect in the ack cycle
    if (wr) begin
      case (AVS_REQ.address)
        `ADCC_OFS_CTRL: begin
          next_s.ch = AVS_REQ.writedata[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
          next_s.sel = w_sel;
          next_s.start = w_start;
          if (w_sel != s.sel) begin
            next_s.phase = ST_IDLE;
            // deselect ends cleanly; reselect waits for a start pulse
            next_s.pending = (w_sel != 3'h0);
          end
          if (w_start && !s.start && w_sel != 3'h0) begin
            next_s.phase = ST_RESET;
            next_s.pending = 1'b1;
            next_s.win_cnt = 6'h0;
          end
          if (!w_start && s.start && s.phase == ST_RESET && w_sel != 3'h0) begin
            launch = 1'b1;
            next_s.phase = ST_CONV;
            next_s.sar = 12'h800;
            next_s.bit_idx = `ADCC_MSB;
            next_s.div_cnt = 5'h0;
          end
          if (w_sel == 3'h0) begin
            next_s.phase = ST_IDLE;
            next_s.pending = 1'b0;
          end
        end
        `ADCC_OFS_CLK: next_s.clk_sel = AVS_REQ.writedata[1:0];
        `ADCC_OFS_STAT: begin
          next_s.st_done = s.st_done & AVS_REQ.writedata[`ADCC_STAT_DONE];
          next_s.st_late = s.st_late & AVS_REQ.writedata[`ADCC_STAT_LATE];
        end
        `ADCC_OFS_IEN: next_s.ien = AVS_REQ.writedata[3:0];
        default: begin
        end
      endcase
    end
    // Reading the status register clears both flags
    if (rd && AVS_REQ.address == `ADCC_OFS_STAT) begin
      next_s.st_done = 1'b0;
      next_s.st_late = 1'b0;
    end
    // Set beats clear so no end event is lost
    if (fin) begin
      next_s.st_done = 1'b1;
    end
    // a late falling step is reported but still honoured
    if (launch && s.win_cnt >= 6'(`ADCC_START_WINDOW_CLKS)) begin
      next_s.st_late = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      next_s_reset();
    end else begin
      s <= next_s;
    end
  end

  task automatic next_s_reset();
    s <= '0;
    s.sel <= `ADCC_SEL_RST;
    s.ch <= `ADCC_CH_RST;
    s.clk_sel <= `ADCC_CLK_RST;
    s.ien <= `ADCC_IEN_RST;
    s.phase <= ST_IDLE;
  endtask : next_s_reset

  // Bus answer; waitrequest is combinational so the master sees one wait
  assign AVS_RSP.readdata = s.readdata;
  assign AVS_RSP.waitrequest = req & ~s.ack;

  // three enables gate the end-of-conversion request
  assign IRQ = s.ien[`ADCC_IEN_GLOBAL]
      & ((s.st_done & s.ien[`ADCC_IEN_CONV] & s.ien[`ADCC_IEN_GROUP])
      | (s.st_late & s.ien[`ADCC_IEN_LATE]));

  // analog side powered only with a nonzero selection
  // control 0x20 powers up with input zero connected
  // half-step offset lives in the analog trial reference
  assign ANA.power = (s.sel != 3'h0);
  assign ANA.channel = s.ch;
  assign ANA.reset = (s.phase == ST_RESET);
  assign ANA.trial = s.sar;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence conv_launch;
    $rose(s.phase == ST_CONV) && s.clk_sel == 2'h1;
  endsequence

  sequence msb_held;
    (s.bit_idx == 4'hB && s.phase == ST_CONV) [*7] ##1 (s.bit_idx == 4'hB);
  endsequence

  pend_conv_a: assert property (s.phase == ST_CONV |-> s.pending && ANA.power)
    else $error("pending low during conversion");

  done_result_a: assert property (fin |=> !s.pending && s.st_done && s.result == $past(fin_code))
    else $error("result, flag and request not updated together");

  irq_gate_a: assert property (!(s.ien[`ADCC_IEN_GLOBAL] && s.ien[`ADCC_IEN_GROUP]) && !s.st_late |-> !IRQ)
    else $error("interrupt without all enables");

  power_off_a: assert property (s.sel == 3'h0 |-> !ANA.power && s.phase == ST_IDLE)
    else $error("converter active while deselected");

  desel_clean_a: assert property (wr && AVS_REQ.address == `ADCC_OFS_CTRL && AVS_REQ.writedata[5:3] == 3'h0 |=> !s.pending ##1 !s.pending)
    else $error("pending left set after deselect");

  // divide by eight spacing of trial bits
  div_eight_a: assert property (conv_launch |-> msb_held ##1 (s.bit_idx == 4'hA || s.phase != ST_CONV))
    else $error("trial bit spacing is not eight clocks");

  hi_byte_a: assert property (AVS_REQ.read && s.ack && AVS_REQ.address == `ADCC_OFS_RHI && !$past(fin) |-> AVS_RSP.readdata == {24'h0, s.result[11:4]})
    else $error("upper byte layout wrong");

  lo_byte_a: assert property (AVS_REQ.read && s.ack && AVS_REQ.address == `ADCC_OFS_RLO && !$past(fin) |-> AVS_RSP.readdata == {24'h0, s.result[3:0], 4'h0})
    else $error("lower byte layout wrong");

  // prompt start pulse is not reported late
  start_window_a: assert property (launch && s.win_cnt < 6'd40 && !s.st_late |=> !s.st_late)
    else $error("prompt start flagged late");

  // end of conversion raises the request
  req_flag_a: assert property (fin |=> s.st_done)
    else $error("request flag not set at conversion end");

endmodule : adcc_top
`default_nettype wire

// ===== tb/adcc_top_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_top_test;
  import adcc_pkg::*;
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [11:0] target;
    logic [3:0] ien;
    logic irq;
  } adcc_row_t;
  logic clk;
  logic rstn;
  logic comp;
  logic irq;
  adcc_avs_req_t req;
  adcc_avs_rsp_t rsp;
  adcc_ana_t ana;
  logic [11:0] target;
  logic [31:0] rd;
  int errors;
  int n_checks;
  int cnt;
  adcc_row_t rows [4];

  adcc_top adcc_top_i (
    .CLK(clk), .RSTN(rstn), .AVS_REQ(req), .AVS_RSP(rsp), .IRQ(irq), .ANA(ana), .COMP_IN(comp)
  );

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ideal comparator; one register stage keeps it inside the settle budget
  always @(posedge clk) begin
    comp <= (target >= ana.trial);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // One Avalon access; waitrequest and readdata are read at the rising edge,
  // before the design's registers move, so they are the values of that edge
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= addr;
    req.writedata <= data;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rsp.waitrequest === 1'b0) break;
    end
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n == 20) begin
      errors++;
      summarize();
    end
  endtask : bus

  initial begin
    req = '0;
    comp = 1'b0;
    target = 12'h000;
    rstn = 1'b0;
    errors = 0;
    n_checks = 0;
    rows[0] = '{2'h0, 12'h000, 4'hD, 1'b1};
    rows[1] = '{2'h1, 12'hA5C, 4'h5, 1'b0};
    rows[2] = '{2'h2, 12'hFFF, 4'h9, 1'b0};
    rows[3] = '{2'h3, 12'h321, 4'hF, 1'b1};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset values; control, clock, lower byte and enable registers read zero
    check("irq_rst", 32'(irq), 32'h0);
    check("ana_rst", 32'(ana), 32'h0);
    foreach (rows[i]) begin
      bus(1'b0, 5'(i * 4 + 4 * (i / 2) + 4 * (i / 3)), 32'h0);
      check("reg_rst", rd, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      target = rows[i].target;
      bus(1'b1, `ADCC_OFS_CLK, 32'(rows[i].clk_sel));
      bus(1'b1, `ADCC_OFS_IEN, 32'(rows[i].ien));
      bus(1'b1, `ADCC_OFS_CTRL, 32'h20 | 32'(i));
      // Write lands at the edge the task returns on; let it settle
      @(negedge clk);
      check("power", 32'(ana.power), 32'h1);
      check("channel", 32'(ana.channel), 32'(i));
      // start pulse right after the selection write
      bus(1'b1, `ADCC_OFS_CTRL, 32'hA0 | 32'(i));
      bus(1'b0, `ADCC_OFS_CTRL, 32'h0);
      check("pend_rise", 32'(rd[6]), 32'h1);
      check("ana_reset", 32'(ana.reset), 32'h1);
      bus(1'b1, `ADCC_OFS_CTRL, 32'h20 | 32'(i));
      // Length of the first trial step is the conversion clock period
      for (cnt = 0; cnt < 100; cnt++) begin
        @(negedge clk);
        if (ana.trial !== 12'h800) break;
      end
      check("step_len", 32'(cnt), 32'(4 << rows[i].clk_sel));
      // Poll pending until the conversion ends
      for (cnt = 0; cnt < 300; cnt++) begin
        bus(1'b0, `ADCC_OFS_CTRL, 32'h0);
        if (rd[6] === 1'b0) break;
      end
      check("pend_fall", 32'(rd[6]), 32'h0);
      check("irq_end", 32'(irq), 32'(rows[i].irq));
      bus(1'b0, `ADCC_OFS_RLO, 32'h0);
      check("lo_byte", rd, 32'({rows[i].target[3:0], 4'h0}));
      bus(1'b0, `ADCC_OFS_RHI, 32'h0);
      check("hi_byte", rd, 32'(rows[i].target[11:4]));
      // Odd rows clear by writing zero, even rows by reading
      if (i % 2 == 1) begin
        bus(1'b1, `ADCC_OFS_STAT, 32'h0);
      end
      bus(1'b0, `ADCC_OFS_STAT, 32'h0);
      check("status", rd, 32'((i + 1) % 2));
      @(negedge clk);
      check("irq_clr", 32'(irq), 32'h0);
    end
    // Write to an unmapped offset is dropped
    bus(1'b1, 5'h18, 32'hFF);
    bus(1'b0, 5'h18, 32'h0);
    check("unmapped", rd, 32'h0);
    // Clearing the select field drops pending and power, no pulse needed
    bus(1'b1, `ADCC_OFS_CTRL, 32'hA0);
    bus(1'b1, `ADCC_OFS_CTRL, 32'h00);
    bus(1'b0, `ADCC_OFS_CTRL, 32'h0);
    check("sel_zero", rd, 32'h0);
    check("power_off", 32'(ana.power), 32'h0);
    // A start rise with a zero field is ignored
    bus(1'b1, `ADCC_OFS_CTRL, 32'h80);
    bus(1'b0, `ADCC_OFS_CTRL, 32'h0);
    check("start_off", 32'(rd[6]), 32'h0);
    // A falling step long after the rise still launches but is flagged late
    bus(1'b1, `ADCC_OFS_CTRL, 32'h20);
    bus(1'b1, `ADCC_OFS_CTRL, 32'hA0);
    repeat (45) @(posedge clk);
    bus(1'b1, `ADCC_OFS_CTRL, 32'h20);
    bus(1'b0, `ADCC_OFS_STAT, 32'h0);
    check("late", 32'(rd[1]), 32'h1);
    summarize();
  end
endmodule : adcc_top_test
`default_nettype wire
